// ==== common/nfh_pkg.sv ====
// Package: constants and types for the NAND flash host controller
package nfh_pkg;
  // APB register offsets
  localparam logic [7:0] NFH_CTRL_OFS = 8'h00;
  localparam logic [7:0] NFH_STAT_OFS = 8'h04;
  localparam logic [7:0] NFH_DATA_OFS = 8'h08;
  // Control register fields
  localparam int NFH_CTRL_GO_BIT = 0;
  localparam int NFH_CTRL_WP_BIT = 1;
  localparam int NFH_CTRL_KIND_LSB = 8;
  localparam int NFH_CTRL_BYTE_LSB = 16;
  localparam int NFH_CTRL_LOCK_BIT = 24;
  // Status register fields
  localparam int NFH_STAT_BUSY_BIT = 0;
  localparam int NFH_STAT_RDY_BIT = 1;
  localparam int NFH_STAT_INIT_BIT = 2;
  localparam int NFH_STAT_REJ_BIT = 3;
  localparam int NFH_STAT_LOCK_BIT = 4;
  localparam int NFH_STAT_DATA_LSB = 8;
  // Reset values
  localparam logic [31:0] NFH_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] NFH_DATA_RST = 8'h00;
  // Device command codes; reset must come first after power-on
  localparam logic [7:0] NFH_CMD_RESET = 8'hff;
  localparam logic [7:0] NFH_CMD_STATUS = 8'h70;
  // Page geometry
  localparam int NFH_PAGE_MAIN = 4096;
  localparam int NFH_PAGE_SPARE = 256;
  localparam int NFH_PAGE_BYTES = NFH_PAGE_MAIN + NFH_PAGE_SPARE;
  localparam int NFH_BLOCK_PAGES = 64;
  localparam int NFH_LOCK_BLOCKS = 48;
  // Strobe timing: 30 ns cycle asked for; 15 ns halves round up to one 25 ns clock each
  localparam int NFH_CLK_PS = 25000;
  localparam int NFH_TCYC_PS = 30000;
  localparam int NFH_HALF_PS = NFH_TCYC_PS / 2;
  localparam int NFH_HALF_CYC_I = (NFH_HALF_PS + NFH_CLK_PS - 1) / NFH_CLK_PS;
  localparam logic [3:0] NFH_HALF_CYC = 4'(NFH_HALF_CYC_I);
  // Longest page read busy times and typical page program times the host can expect
  localparam int NFH_TRD_ECC_US = 115;
  localparam int NFH_TRD_US = 30;
  localparam int NFH_TPROG_US = 200;
  localparam int NFH_TPROG_ECC_US = 240;

  // Kinds of bus cycle the host can run
  typedef enum logic [1:0] {
    NFH_K_CMD = 2'b00,
    NFH_K_ADDR = 2'b01,
    NFH_K_DIN = 2'b10,
    NFH_K_DOUT = 2'b11
  } nfh_kind_t;

  // Pins driven toward the flash
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] io_out;
    logic io_oe;
  } nfh_pins_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } nfh_apb_req_t;
endpackage : nfh_pkg

// ==== design/nfh_host.sv ====
// NAND flash host controller: APB registers driving the flash pins
`timescale 1ns/1ps
`default_nettype none
// Contract
// (RL1) One shared 8-bit bus for all bytes
// (RL2) Device latches command while command latch high
// (RL3) Device latches address while address latch high
// (RL4) Device splits address into row and column
// (RL5) Chip enable selects target; deselected ignores strobes
// (RL6) Write strobe pulse transfers each input byte
// (RL7) Read strobe pulse fetches next output byte
// (RL8) Write protect gates program and erase
// (RL9) Ready/busy open-drain, low while busy
// (RL10) Lock strap high at power-up enables locking; here lock_o resets low and goes high only on a later control write
// (RL11) Reset command first after power-on
// (RL12) On-die correction off until set-feature
// (RL13) Page is 4096 main plus 256 spare
// (RL14) Block holds 64 pages, one plane
// (RL15) Program/read by page, erase by block
// (RL16) Cache and data registers split in cache mode
// (RL17) Status byte: done, pass/fail, protect
// (RL18) Page read busy at most 115/30 us
// (RL19) Page program typically 200/240 us
// (RL20) Permanent locking only for blocks 0-47
// (RL21) Write protect low blocks program and erase
// (RL22) Command latched on write strobe rise
// (RL23) Busy device ignores non-status commands
module nfh_host (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic [7:0] io_in_i,
  input wire logic rb_n_i,
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic re_n_o,
  output logic wp_n_o,
  output logic lock_o,
  output logic io_oe_o,
  output logic [7:0] io_out_o
);
  import nfh_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Controller state
  typedef enum logic [1:0] {
    NFH_H_IDLE = 2'b00,
    NFH_H_RUN = 2'b01,
    NFH_H_WAIT = 2'b10
  } nfh_hst_t;

  nfh_hst_t st_r, st_nxt;
  logic init_done_r;
  logic reject_r;
  logic wp_r;
  logic lock_r;
  logic ce_r;
  logic [7:0] rdbyte_r;
  logic rb_q_r;
  logic go_r;
  nfh_kind_t kind_r;
  logic [7:0] byte_r;
  logic seq_done;
  logic [7:0] seq_rdata;
  logic seq_cle, seq_ale, seq_we_n, seq_re_n, seq_oe;
  logic [7:0] seq_out;

  ////////////////////////////////////////////////////////////////////////
  // True when a request is a command cycle with the given code
  function automatic logic is_cmd(input nfh_kind_t k, input logic [7:0] b,
                                  input logic [7:0] code);
    return (k == NFH_K_CMD) && (b == code);
  endfunction : is_cmd

  // Register decode for the APB slave; one select wire per register
  wire sel_ctrl = (paddr_i == NFH_CTRL_OFS);
  wire sel_stat = (paddr_i == NFH_STAT_OFS);
  wire sel_data = (paddr_i == NFH_DATA_OFS);
  // Writes act in the access cycle, which is always the answer cycle
  wire acc = psel_i && penable_i;
  wire wr_ctrl = acc && pwrite_i && sel_ctrl;
  wire hit = sel_ctrl || sel_stat || sel_data;
  wire go_req = wr_ctrl && pwdata_i[NFH_CTRL_GO_BIT];
  wire nfh_kind_t req_kind = nfh_kind_t'(pwdata_i[NFH_CTRL_KIND_LSB +: 2]);
  wire [7:0] req_byte = pwdata_i[NFH_CTRL_BYTE_LSB +: 8];
  wire is_reset_cmd = is_cmd(req_kind, req_byte, NFH_CMD_RESET);
  wire is_stat_cmd = is_cmd(req_kind, req_byte, NFH_CMD_STATUS);
  // Before the first reset command only reset may go out
  wire allow_pre = init_done_r || is_reset_cmd; // RL11
  // While the device is busy only status traffic is useful
  wire allow_busy = rb_q_r || is_stat_cmd || (req_kind == NFH_K_DOUT); // RL23
  // Refused requests start no flash cycle and raise the flag; WP and lock bits still take the write
  wire accept = go_req && (st_r == NFH_H_IDLE) && allow_pre && allow_busy;
  wire refuse = go_req && !accept;

  ////////////////////////////////////////////////////////////////////////
  // Sequence control
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      NFH_H_IDLE: if (accept) st_nxt = NFH_H_RUN;
      NFH_H_RUN: st_nxt = NFH_H_WAIT;
      NFH_H_WAIT: if (seq_done) st_nxt = NFH_H_IDLE;
      default: st_nxt = NFH_H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r <= NFH_H_IDLE;
      go_r <= 1'b0;
      kind_r <= NFH_K_CMD;
      byte_r <= NFH_DATA_RST;
    end else begin
      st_r <= st_nxt;
      go_r <= accept;
      if (accept) begin
        kind_r <= req_kind;
        byte_r <= req_byte;
      end
    end
  end

  // Software-held control bits and flags
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wp_r <= NFH_CTRL_RST[NFH_CTRL_WP_BIT];
      lock_r <= NFH_CTRL_RST[NFH_CTRL_LOCK_BIT];
      init_done_r <= 1'b0;
      reject_r <= 1'b0;
      rb_q_r <= 1'b0;
    end else begin
      // One flop on the ready level; the pin is taken as synchronous
      rb_q_r <= rb_n_i; // RL9
      if (wr_ctrl) begin
        wp_r <= pwdata_i[NFH_CTRL_WP_BIT]; // RL21
        lock_r <= pwdata_i[NFH_CTRL_LOCK_BIT]; // RL10
      end
      if (accept && is_reset_cmd) init_done_r <= 1'b1; // RL11
      // A refusal in the same cycle as a clear keeps the flag set
      if (refuse) reject_r <= 1'b1;
      else if (wr_ctrl) reject_r <= 1'b0;
    end
  end

  // Chip enable held low through the bus cycle only
  // Read byte kept until the next data-out cycle replaces it
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ce_r <= 1'b1;
      rdbyte_r <= NFH_DATA_RST;
    end else begin
      if (accept) ce_r <= 1'b0; // RL5
      else if (st_r == NFH_H_WAIT && seq_done) ce_r <= 1'b1; // RL5
      if (seq_done && kind_r == NFH_K_DOUT) rdbyte_r <= seq_rdata; // RL17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe sequencer
  nfh_strobe u_strobe (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .start_i(go_r),
    .kind_i(kind_r),
    .byte_i(byte_r),
    .io_in_i(io_in_i),
    .done_o(seq_done),
    .rdata_o(seq_rdata),
    .cle_o(seq_cle),
    .ale_o(seq_ale),
    .we_n_o(seq_we_n),
    .re_n_o(seq_re_n),
    .io_oe_o(seq_oe),
    .io_out_o(seq_out)
  );

  // Pin outputs are flops in the sequencer or here
  assign cle_o = seq_cle; // RL2
  assign ale_o = seq_ale;
  assign we_n_o = seq_we_n;
  assign re_n_o = seq_re_n;
  assign io_oe_o = seq_oe;
  assign io_out_o = seq_out;
  assign ce_n_o = ce_r;
  assign wp_n_o = wp_r; // RL8
  assign lock_o = lock_r;

  ////////////////////////////////////////////////////////////////////////
  // APB answer: one wait-free access phase, registered read data
  wire [31:0] stat_word = {16'h0000, rdbyte_r, 3'b000, lock_r, reject_r,
                           init_done_r, rb_q_r, (st_r != NFH_H_IDLE)};
  // Control readback: lock and protect levels only, GO reads as zero
  wire [31:0] ctrl_word = {7'h00, lock_r, 22'h000000, wp_r, 1'b0};
  wire [31:0] rd_mux = sel_stat ? stat_word :
                       sel_ctrl ? ctrl_word :
                       sel_data ? {24'h000000, rdbyte_r} :
                       32'h0000_0000;

  // A master that stretches penable gets no second pready, so the
  // transfer must finish on this one
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      prdata_o <= rd_mux;
      pslverr_o <= psel_i && !penable_i && !hit;
    end
  end
endmodule : nfh_host
`default_nettype wire

// ==== design/nfh_strobe.sv ====
// Strobe sequencer: runs one bus cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module nfh_strobe (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire nfh_pkg::nfh_kind_t kind_i,
  input wire logic [7:0] byte_i,
  input wire logic [7:0] io_in_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic re_n_o,
  output logic io_oe_o,
  output logic [7:0] io_out_o
);
  import nfh_pkg::*;

  typedef enum logic [1:0] {
    NFH_S_IDLE = 2'b00,
    NFH_S_LOW = 2'b01,
    NFH_S_HIGH = 2'b10
  } nfh_sst_t;

  nfh_sst_t st_r, st_nxt;
  logic [3:0] cnt_r;
  logic is_rd_r;
  wire half_done = (cnt_r == NFH_HALF_CYC - 4'd1);

  ////////////////////////////////////////////////////////////////////////
  // Phase sequence: strobe low half, then high half
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      NFH_S_IDLE: if (start_i) st_nxt = NFH_S_LOW;
      NFH_S_LOW: if (half_done) st_nxt = NFH_S_HIGH;
      NFH_S_HIGH: if (half_done) st_nxt = NFH_S_IDLE;
      default: st_nxt = NFH_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r <= NFH_S_IDLE;
      cnt_r <= 4'd0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_r == NFH_S_IDLE || half_done) ? 4'd0 : cnt_r + 4'd1;
    end
  end

  // Pin drive; latches fixed for whole cycle so the device sees stable lines
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      we_n_o <= 1'b1;
      re_n_o <= 1'b1;
      io_oe_o <= 1'b0;
      io_out_o <= NFH_DATA_RST;
      is_rd_r <= 1'b0;
    end else if (st_r == NFH_S_IDLE && start_i) begin
      cle_o <= (kind_i == NFH_K_CMD); // RL22
      ale_o <= (kind_i == NFH_K_ADDR); // RL3
      is_rd_r <= (kind_i == NFH_K_DOUT);
      we_n_o <= (kind_i == NFH_K_DOUT); // RL6
      re_n_o <= (kind_i != NFH_K_DOUT); // RL7
      io_oe_o <= (kind_i != NFH_K_DOUT); // RL1
      io_out_o <= byte_i; // RL1
    end else if (st_r == NFH_S_LOW && half_done) begin
      we_n_o <= 1'b1; // RL6
      re_n_o <= 1'b1; // RL7
    end else if (st_r == NFH_S_HIGH && half_done) begin
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      io_oe_o <= 1'b0;
    end
  end

  // Read byte sampled just before the read strobe rises
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_o <= NFH_DATA_RST;
      done_o <= 1'b0;
    end else begin
      done_o <= (st_r == NFH_S_HIGH) && half_done;
      if (st_r == NFH_S_LOW && half_done && is_rd_r) begin
        rdata_o <= io_in_i; // RL7
      end
    end
  end
endmodule : nfh_strobe
`default_nettype wire

// ==== test/nfh_flash_model.sv ====
// Behavioural flash target on the host's pins
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model (
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic rb_n_o
);
  import nfh_pkg::*;
  localparam logic [12:0] LAST_COL = 13'(NFH_PAGE_BYTES - 1);
  logic [7:0] cmd_r = 8'h00;
  logic [7:0] addr_r = 8'h00;
  logic [7:0] din_r = 8'h00;
  logic [12:0] ptr_r = 13'h0000;
  logic [7:0] q_r = 8'h00;
  logic busy_r = 1'b0;
  logic stat_r = 1'b0;
  logic fail_r = 1'b0;
  logic init_r = 1'b0;
  logic order_err_r = 1'b0;
  logic take;
  // Busy target only listens for the status command
  assign take = !ce_n_i && re_n_i &&
                (!busy_r || (cle_i && io_i == 8'h70));
  // Bytes land on the rising write strobe
  always @(posedge we_n_i) begin
    if (take && cle_i && !ale_i) begin
      cmd_r <= io_i;
      stat_r <= io_i == 8'h70;
      init_r <= init_r || io_i == 8'hff;
      order_err_r <= order_err_r || (!init_r && io_i != 8'hff);
      if (io_i == 8'h10 || io_i == 8'hd0) begin
        fail_r <= !wp_n_i;
        busy_r <= wp_n_i;
      end
    end else if (take && ale_i && !cle_i) begin
      addr_r <= io_i;
      ptr_r <= {5'h00, io_i};
    end else if (take && !cle_i && !ale_i) begin
      din_r <= io_i;
    end
  end
  // Array time, shortened from the typical program time
  always @(posedge busy_r) busy_r <= #2000 1'b0;
  // Status byte or next data byte per read strobe
  always @(negedge re_n_i) begin
    if (!ce_n_i) begin
      q_r <= stat_r ? {wp_n_i, !busy_r, 5'h00, fail_r} : ptr_r[7:0];
    end
  end
  // Column wraps at the end of main plus spare area
  always @(posedge re_n_i) begin
    if (!ce_n_i && !stat_r) begin
      ptr_r <= (ptr_r == LAST_COL) ? 13'h0000 : ptr_r + 13'h0001;
    end
  end
  // Released bus flips so a stale byte never passes
  assign io_o = (!ce_n_i && !re_n_i) ? q_r : ~q_r;
  assign rb_n_o = !busy_r;
endmodule : nfh_flash_model
`default_nettype wire

// ==== test/nfh_host_bench.sv ====
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module nfh_host_bench;
  import nfh_pkg::*;
  typedef struct packed {
    nfh_kind_t k;
    logic [7:0] b;
    logic [7:0] e;
  } nfh_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, rb_n, ce_n, cle, ale, we_n, re_n, wp_n, lock, io_oe;
  logic [31:0] prdata, rdv;
  logic [7:0] io_in, io_out;
  logic errv;
  logic wpv = 1'b0;
  int mismatches = 0;
  int n_compared = 0;
  nfh_row_t rows[10];
  always #12.5 clk = ~clk;
  nfh_host i_dut (.core_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .io_in_i(io_in), .rb_n_i(rb_n), .ce_n_o(ce_n),
    .cle_o(cle), .ale_o(ale), .we_n_o(we_n), .re_n_o(re_n), .wp_n_o(wp_n),
    .lock_o(lock), .io_oe_o(io_oe), .io_out_o(io_out));
  nfh_flash_model i_dev (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale),
    .we_n_i(we_n), .re_n_i(re_n), .wp_n_i(wp_n), .io_i(io_out),
    .io_o(io_in), .rb_n_o(rb_n));
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bound(input logic ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask : bound
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    bound(pready);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll status until a bit reaches a level
  task automatic poll(input int bit_i, input logic lvl);
    int n;
    n = 0;
    do begin
      apb(1'b0, NFH_STAT_OFS, 32'h0);
      n++;
    end while (rdv[bit_i] !== lvl && n < 100);
    bound(rdv[bit_i] === lvl);
  endtask : poll
  // One flash cycle through the control word
  task automatic op(input nfh_kind_t k, input logic [7:0] b);
    apb(1'b1, NFH_CTRL_OFS, (32'(b) << NFH_CTRL_BYTE_LSB) |
      (32'(k) << NFH_CTRL_KIND_LSB) | (32'(wpv) << NFH_CTRL_WP_BIT) |
      (32'h1 << NFH_CTRL_GO_BIT));
    poll(NFH_STAT_BUSY_BIT, 1'b0);
  endtask : op
  initial begin
    rows[0] = '{NFH_K_CMD, 8'hff, 8'hff};
    rows[1] = '{NFH_K_CMD, 8'h00, 8'h00};
    rows[2] = '{NFH_K_ADDR, 8'h10, 8'h10};
    rows[3] = '{NFH_K_DOUT, 8'h00, 8'h10};
    rows[4] = '{NFH_K_DOUT, 8'h00, 8'h11};
    rows[5] = '{NFH_K_DIN, 8'ha5, 8'ha5};
    rows[6] = '{NFH_K_DIN, 8'h5a, 8'h5a};
    rows[7] = '{NFH_K_CMD, 8'h10, 8'h10};
    rows[8] = '{NFH_K_CMD, 8'h70, 8'h70};
    rows[9] = '{NFH_K_DOUT, 8'h00, 8'h41};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      op(rows[i].k, rows[i].b);
      case (rows[i].k)
        NFH_K_CMD: chk(i_dev.cmd_r, rows[i].e);
        NFH_K_ADDR: chk(i_dev.addr_r, rows[i].e);
        NFH_K_DIN: chk(i_dev.din_r, rows[i].e);
        default: chk(rdv[15:8], rows[i].e);
      endcase
    end
    // Unprotected program holds the target busy
    wpv = 1'b1;
    op(NFH_K_CMD, 8'h10);
    chk(8'(rdv[NFH_STAT_RDY_BIT]), 8'h00);
    op(NFH_K_CMD, 8'h00);
    chk(8'(rdv[NFH_STAT_REJ_BIT]), 8'h01);
    op(NFH_K_CMD, NFH_CMD_STATUS);
    op(NFH_K_DOUT, 8'h00);
    chk(rdv[15:8], 8'h80);
    poll(NFH_STAT_RDY_BIT, 1'b1);
    op(NFH_K_DOUT, 8'h00);
    chk(rdv[15:8], 8'hc0);
    apb(1'b0, NFH_DATA_OFS, 32'h0);
    chk(rdv[7:0], 8'hc0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(8'(errv), 8'h01);
    apb(1'b1, NFH_CTRL_OFS, 32'h1 << NFH_CTRL_LOCK_BIT);
    @(posedge clk);
    chk(8'(lock), 8'h01);
    chk(8'(wp_n), 8'h00);
    apb(1'b0, NFH_CTRL_OFS, 32'h0);
    chk(rdv[31:24], 8'h01);
    chk(rdv[7:0], 8'h00);
    // Second reset: nothing but the reset command may pass
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    op(NFH_K_CMD, 8'h00);
    chk(8'(rdv[NFH_STAT_REJ_BIT]), 8'h01);
    chk(i_dev.cmd_r, NFH_CMD_STATUS);
    op(NFH_K_CMD, NFH_CMD_RESET);
    chk(8'(rdv[NFH_STAT_INIT_BIT]), 8'h01);
    chk(8'(i_dev.order_err_r), 8'h00);
    end_of_test();
  end
endmodule : nfh_host_bench
`default_nettype wire

// ==== test/nfh_host_monitor.sv ====
// Port checker for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module nfh_host_checker (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic ce_n_o,
  input wire logic cle_o,
  input wire logic ale_o,
  input wire logic we_n_o,
  input wire logic re_n_o,
  input wire logic wp_n_o,
  input wire logic lock_o,
  input wire logic io_oe_o,
  input wire logic [7:0] io_out_o
);
  import nfh_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Control write without a flash cycle
  sequence s_ctrl;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == NFH_CTRL_OFS
      && !pwdata_i[NFH_CTRL_GO_BIT];
  endsequence
  // Select, one strobe cycle low, then release two cycles on
  sequence s_open;
    $fell(ce_n_o);
  endsequence
  sequence s_walk;
    ##1 (!we_n_o || !re_n_o) ##1 (we_n_o && re_n_o) ##2 ce_n_o;
  endsequence
  property p_ready; psel_i && !penable_i |=> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("no pready");
  property p_walk; s_open |-> s_walk; endproperty
  a_walk: assert property (p_walk) else $error("bad cycle");
  property p_idle;
    ce_n_o |-> !cle_o && !ale_o && we_n_o && re_n_o && !io_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("pins busy");
  property p_cmd;
    !we_n_o && cle_o |-> !ce_n_o && !ale_o && re_n_o && io_oe_o;
  endproperty
  a_cmd: assert property (p_cmd) else $error("bad command");
  property p_addr; !we_n_o && ale_o |-> !cle_o && io_oe_o; endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_hold;
    !we_n_o |=> io_oe_o && $stable(io_out_o) && $stable(cle_o)
      && $stable(ale_o);
  endproperty
  a_hold: assert property (p_hold) else $error("bus moved");
  property p_dout;
    !re_n_o |-> !ce_n_o && we_n_o && !io_oe_o && !cle_o && !ale_o;
  endproperty
  a_dout: assert property (p_dout) else $error("bad read");
  property p_ctrl;
    s_ctrl |=> wp_n_o == $past(pwdata_i[NFH_CTRL_WP_BIT])
      && lock_o == $past(pwdata_i[NFH_CTRL_LOCK_BIT]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("pins stale");
endmodule : nfh_host_checker
bind nfh_host nfh_host_checker i_chk (.core_clk_i, .reset_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .ce_n_o, .cle_o,
  .ale_o, .we_n_o, .re_n_o, .wp_n_o, .lock_o, .io_oe_o, .io_out_o);
`default_nettype wire
